//--- core/jsc_pkg.sv
// Package of constants and types for the join and scan configuration block.
// Overview of operation
// - Successful label lookup loads target address, replies OK, leaves command mode.
// - Lookup ends with ERROR after 200 ms silence or when no parameter given.
// - Coordinator role flag is read/write; 0 end node, 1 coordinator; resets 0.
// - Mask bit n enables scanning of channel 0x0B plus n.
// - Mask applies to command scans, end-node joining and coordinator startup scans.
// - Mask resets to 0x1FFE; high-power variant forbids bits 0, 14, 15.
// - Scan time is enabled channels times two to exponent times 15.36 ms.
// - Survey length exponent is read/write, range 0 to 0x0F, resets to 4.
// - Coordinator uses exponent for network scan and energy scan lengths.
// - End-node bit 0 clear joins only matching network identifier.
// - End-node bit 1 clear joins only coordinator on the set channel.
// - End-node bit 2 enables join retries until success; beacon networks always join.
// - End-node bit 3 makes a pin wake-up send a poll request.
// - End-node options range 0 to 0x0F, reset 0; bits 4 to 7 reserved.
// - Coordinator bit 0 scans for free network identifier and replaces on conflict.
// - Coordinator bit 1 runs energy scan and moves to the free channel.
// - Coordinator bit 2 accepts join requests; clear refuses all joiners.
// - Coordinator options range 0 to 7, reset 6; bits 3 to 7 reserved.
package jsc_pkg;
   // ***************************************************************
   // Register selection and reset values.
   // ***************************************************************
   typedef enum logic [2:0] {
      JSC_SEL_ROLE, JSC_SEL_MASK, JSC_SEL_EXP, JSC_SEL_ENOPT, JSC_SEL_COPT
   } jsc_sel_t;
   localparam logic        ROLE_RST    = 1'b0;
   localparam logic [15:0] MASK_RST    = 16'h1ffe;
   localparam logic [15:0] MASK_HP_BAN = 16'hc001;
   localparam logic [3:0]  EXP_RST     = 4'h4;
   localparam logic [7:0]  ENOPT_RST   = 8'h00;
   localparam logic [7:0]  ENOPT_MASK  = 8'h0f;
   localparam logic [7:0]  COPT_RST    = 8'h06;
   localparam logic [7:0]  COPT_MASK   = 8'h07;
   localparam int          EN_PAN_BIT  = 0;
   localparam int          EN_LANE_BIT = 1;
   localparam int          EN_AUTO_BIT = 2;
   localparam int          EN_POLL_BIT = 3;
   localparam int          CO_PAN_BIT  = 0;
   localparam int          CO_LANE_BIT = 1;
   localparam int          CO_ACPT_BIT = 2;
   localparam logic [7:0]  LANE_BASE   = 8'h0b;
   // ***************************************************************
   // Timing.
   // ***************************************************************
   localparam int CLK_HZ         = 100_000_000;
   localparam int LOOKUP_MS      = 200;
   localparam int LOOKUP_CYC     = LOOKUP_MS * (CLK_HZ / 1000);
   localparam int SCAN_UNIT_NS   = 15_360_000;
   localparam int CLK_NS         = 1_000_000_000 / CLK_HZ;
   localparam int SCAN_UNIT_CYC  = SCAN_UNIT_NS / CLK_NS;
   typedef enum logic [1:0] {JSC_LK_IDLE, JSC_LK_WAIT} jsc_lk_t;
endpackage : jsc_pkg

//--- core/jsc_scan_if.sv
// Interface carrying the scan request and its timing between modules.
`timescale 1ns/1ns
interface jsc_scan_if;
   logic        start;
   logic [15:0] mask;
   logic [3:0]  exp;
   logic        busy;
   logic        done;
   modport ctl (output start, mask, exp, input busy, done);
   modport tmr (input start, mask, exp, output busy, done);
endinterface : jsc_scan_if

//--- core/jsc_scan_timer.sv
// Scan timer: enabled channel count times two to the exponent scan units.
`timescale 1ns/1ns
module jsc_scan_timer
   import jsc_pkg::*;
#(
   parameter int UNIT_CYC = SCAN_UNIT_CYC
) (
   input  wire logic i_mclk,   // System clock.
   input  wire logic i_reset,  // Asynchronous reset.
   jsc_scan_if.tmr   scan      // Scan request and status.
);
   function automatic logic [4:0] popcnt(input logic [15:0] m);
      logic [4:0] c;
      c = 5'h0;
      for (int i = 0; i < 16; i++) begin
         c = c + {4'h0, m[i]};
      end
      return c;
   endfunction : popcnt

   logic [4:0]  chan_r, chan_nxt;
   logic [15:0] per_r, per_nxt, pld_r, pld_nxt;
   logic [31:0] unit_r, unit_nxt;
   logic        busy_r, busy_nxt, done_r, done_nxt;

   always_comb begin
      chan_nxt = chan_r;
      per_nxt  = per_r;
      pld_nxt  = pld_r;
      unit_nxt = unit_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (!busy_r && scan.start) begin
         chan_nxt = popcnt(scan.mask);
         per_nxt  = 16'h1 << scan.exp;
         // The period is held so that a later exponent write cannot stretch this scan.
         pld_nxt  = 16'h1 << scan.exp;
         unit_nxt = 32'(UNIT_CYC - 1);
         busy_nxt = (popcnt(scan.mask) != 5'h0);
         done_nxt = (popcnt(scan.mask) == 5'h0);
      end else if (busy_r) begin
         if (unit_r != 32'h0) begin
            unit_nxt = unit_r - 32'h1;
         end else begin
            unit_nxt = 32'(UNIT_CYC - 1);
            if (per_r != 16'h1) begin
               per_nxt = per_r - 16'h1;
            end else if (chan_r != 5'h1) begin
               chan_nxt = chan_r - 5'h1;
               per_nxt  = pld_r;
            end else begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         chan_r <= 5'h0;
         per_r  <= 16'h0;
         pld_r  <= 16'h0;
         unit_r <= 32'h0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         chan_r <= chan_nxt;
         per_r  <= per_nxt;
         pld_r  <= pld_nxt;
         unit_r <= unit_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end
   assign scan.busy = busy_r;
   assign scan.done = done_r;
endmodule : jsc_scan_timer

//--- core/jsc_lookup.sv
// Node label lookup sequencer with timeout.
`timescale 1ns/1ns
module jsc_lookup
   import jsc_pkg::*;
#(
   parameter int TIMEOUT_CYC = LOOKUP_CYC
) (
   input  wire logic        i_mclk,      // System clock.
   input  wire logic        i_reset,     // Asynchronous reset.
   input  wire logic        i_start,     // Lookup command pulse.
   input  wire logic        i_has_param, // Label parameter present.
   input  wire logic        i_match,     // Matching module answered.
   input  wire logic [63:0] i_addr,      // Address of the answering module.
   output logic             o_ok,        // Lookup succeeded pulse.
   output logic             o_err,       // Lookup failed pulse.
   output logic [63:0]      o_addr       // Captured address.
);
   jsc_lk_t     st_r, st_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic        ok_r, ok_nxt, err_r, err_nxt;
   logic [63:0] addr_r, addr_nxt;

   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      ok_nxt   = 1'b0;
      err_nxt  = 1'b0;
      addr_nxt = addr_r;
      unique case (st_r)
         JSC_LK_IDLE: begin
            if (i_start && !i_has_param) begin
               err_nxt = 1'b1;
            end else if (i_start) begin
               st_nxt  = JSC_LK_WAIT;
               cnt_nxt = 32'(TIMEOUT_CYC - 1);
            end
         end
         JSC_LK_WAIT: begin
            if (i_match) begin
               addr_nxt = i_addr;
               ok_nxt   = 1'b1;
               st_nxt   = JSC_LK_IDLE;
            end else if (cnt_r == 32'h0) begin
               err_nxt = 1'b1;
               st_nxt  = JSC_LK_IDLE;
            end else begin
               cnt_nxt = cnt_r - 32'h1;
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         st_r   <= JSC_LK_IDLE;
         cnt_r  <= 32'h0;
         ok_r   <= 1'b0;
         err_r  <= 1'b0;
         addr_r <= 64'h0;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         ok_r   <= ok_nxt;
         err_r  <= err_nxt;
         addr_r <= addr_nxt;
      end
   end
   assign o_ok   = ok_r;
   assign o_err  = err_r;
   assign o_addr = addr_r;

   a_lookup_timeout: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == JSC_LK_WAIT && cnt_r == 32'h0 && !i_match) |=> err_r)
      else $error("Lookup timeout did not report an error.");
   a_lookup_noparam: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == JSC_LK_IDLE && i_start && !i_has_param) |=> (err_r && !ok_r))
      else $error("Lookup without parameter did not fail.");
   a_lookup_addr_load: assert property (@(posedge i_mclk) disable iff (i_reset)
      (st_r == JSC_LK_WAIT && i_match) |=> (ok_r && addr_r == $past(i_addr)))
      else $error("Lookup success did not capture the address.");
   c_lookup_ok: cover property (@(posedge i_mclk) disable iff (i_reset) ok_r);
   c_lookup_err: cover property (@(posedge i_mclk) disable iff (i_reset) err_r);
endmodule : jsc_lookup

//--- core/jsc_top.sv
// Join and scan configuration block: registers, scan control and join policy.
`timescale 1ns/1ns
module jsc_top
   import jsc_pkg::*;
#(
   parameter int  LOOKUP_TMO = LOOKUP_CYC,    // Lookup timeout in cycles.
   parameter int  UNIT_CYC   = SCAN_UNIT_CYC, // Scan unit in cycles.
   parameter bit  HIGH_POWER = 1'b0           // High-power variant.
) (
   input  wire logic        i_mclk,          // System clock.
   input  wire logic        i_reset,         // Asynchronous reset.
   input  wire logic        i_wr,            // Register write strobe.
   input  wire logic [2:0]  i_sel,           // Register select.
   input  wire logic [15:0] i_wdata,         // Register write data.
   output logic [15:0]      o_rdata,         // Register read data.
   input  wire logic        i_lookup,        // Label lookup command pulse.
   input  wire logic        i_lookup_param,  // Lookup parameter present.
   input  wire logic        i_lookup_match,  // Matching module answered.
   input  wire logic [63:0] i_lookup_addr,   // Answering module address.
   output logic             o_reply_ok,      // OK reply pulse.
   output logic             o_reply_err,     // ERROR reply pulse.
   output logic             o_exit_cmd,      // Leave command mode pulse.
   output logic [31:0]      o_target_addr_low,  // Target address low word.
   output logic [31:0]      o_target_addr_high, // Target address high word.
   input  wire logic        i_scan_cmd,      // Command-mode scan request pulse.
   input  wire logic        i_join_start,    // Start joining or coordinator startup.
   input  wire logic        i_beacon_net,    // Network uses beacons.
   output logic             o_scan_busy,     // Scan in progress.
   output logic             o_scan_done,     // Scan finished pulse.
   output logic [15:0]      o_active_mask,   // Channels the current scan covers.
   output logic [3:0]       o_active_exp,    // Exponent of the current scan.
   input  wire logic [15:0] i_pan_number,    // Own network identifier.
   input  wire logic [7:0]  i_radio_lane,    // Own channel.
   input  wire logic [15:0] i_cand_pan,      // Candidate coordinator network id.
   input  wire logic [7:0]  i_cand_lane,     // Candidate coordinator channel.
   output logic             o_cand_ok,       // Candidate may be joined.
   input  wire logic        i_joined,        // Join attempt succeeded.
   output logic             o_join_retry,    // Retry join pulse.
   input  wire logic        i_pin_wake,      // Wake-up from the pin pulse.
   output logic             o_poll_req,      // Poll coordinator pulse.
   output logic             o_accept_joiners,// Coordinator takes join requests.
   output logic             o_reassign_pan,  // Coordinator scans for free id.
   output logic             o_reassign_lane  // Coordinator energy scans.
);
   // ***************************************************************
   // Configuration registers.
   // ***************************************************************
   logic        role_r, role_nxt;
   logic [15:0] mask_r, mask_nxt;
   logic [3:0]  exp_r, exp_nxt;
   logic [7:0]  enopt_r, enopt_nxt;
   logic [7:0]  copt_r, copt_nxt;

   always_comb begin
      role_nxt  = role_r;
      mask_nxt  = mask_r;
      exp_nxt   = exp_r;
      enopt_nxt = enopt_r;
      copt_nxt  = copt_r;
      if (i_wr) begin
         unique case (jsc_sel_t'(i_sel))
            JSC_SEL_ROLE:  role_nxt = i_wdata[0];
            JSC_SEL_MASK:  mask_nxt = HIGH_POWER ? (i_wdata & ~MASK_HP_BAN)
                                                 : i_wdata;
            JSC_SEL_EXP:   exp_nxt = i_wdata[3:0];
            JSC_SEL_ENOPT: enopt_nxt = i_wdata[7:0] & ENOPT_MASK;
            JSC_SEL_COPT:  copt_nxt = i_wdata[7:0] & COPT_MASK;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         role_r  <= ROLE_RST;
         mask_r  <= MASK_RST;
         exp_r   <= EXP_RST;
         enopt_r <= ENOPT_RST;
         copt_r  <= COPT_RST;
      end else begin
         role_r  <= role_nxt;
         mask_r  <= mask_nxt;
         exp_r   <= exp_nxt;
         enopt_r <= enopt_nxt;
         copt_r  <= copt_nxt;
      end
   end

   always_comb begin
      unique case (jsc_sel_t'(i_sel))
         JSC_SEL_ROLE:  o_rdata = {15'h0, role_r};
         JSC_SEL_MASK:  o_rdata = mask_r;
         JSC_SEL_EXP:   o_rdata = {12'h0, exp_r};
         JSC_SEL_ENOPT: o_rdata = {8'h0, enopt_r};
         JSC_SEL_COPT:  o_rdata = {8'h0, copt_r};
         default:       o_rdata = 16'h0;
      endcase
   end

   // ***************************************************************
   // Label lookup.
   // ***************************************************************
   logic        lk_ok, lk_err;
   logic [63:0] lk_addr;

   jsc_lookup #(.TIMEOUT_CYC(LOOKUP_TMO)) u_lookup (
      .i_mclk      (i_mclk),
      .i_reset     (i_reset),
      .i_start     (i_lookup),
      .i_has_param (i_lookup_param),
      .i_match     (i_lookup_match),
      .i_addr      (i_lookup_addr),
      .o_ok        (lk_ok),
      .o_err       (lk_err),
      .o_addr      (lk_addr)
   );
   assign o_reply_ok         = lk_ok;
   assign o_exit_cmd         = lk_ok;
   assign o_reply_err        = lk_err;
   assign o_target_addr_low  = lk_addr[31:0];
   assign o_target_addr_high = lk_addr[63:32];

   // ***************************************************************
   // Scan control.
   // ***************************************************************
   jsc_scan_if scan_bus ();
   logic coord_scan;
   logic join_pend_r, join_pend_nxt;
   logic retry_r, retry_nxt, poll_r, poll_nxt;

   // A coordinator startup scan runs only when one of its reassign options is set.
   assign coord_scan = role_r && (copt_r[CO_PAN_BIT] || copt_r[CO_LANE_BIT]);
   assign scan_bus.start = !scan_bus.busy && (i_scan_cmd ||
                           (i_join_start && (coord_scan || !role_r)) ||
                           (retry_r && !role_r));
   assign scan_bus.mask = mask_r;
   assign scan_bus.exp  = exp_r;

   jsc_scan_timer #(.UNIT_CYC(UNIT_CYC)) u_scan (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .scan    (scan_bus)
   );

   logic [15:0] amask_r;
   logic [3:0]  aexp_r;
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         amask_r <= MASK_RST;
         aexp_r  <= EXP_RST;
      end else if (scan_bus.start) begin
         amask_r <= mask_r;
         aexp_r  <= exp_r;
      end
   end
   assign o_active_mask = amask_r;
   assign o_active_exp  = aexp_r;
   assign o_scan_busy   = scan_bus.busy;
   assign o_scan_done   = scan_bus.done;

   // ***************************************************************
   // Join policy.
   // ***************************************************************
   assign o_cand_ok = !role_r &&
                      (enopt_r[EN_PAN_BIT] || i_cand_pan == i_pan_number) &&
                      (enopt_r[EN_LANE_BIT] || i_cand_lane == i_radio_lane);
   assign o_accept_joiners = role_r && copt_r[CO_ACPT_BIT];
   assign o_reassign_pan   = role_r && copt_r[CO_PAN_BIT];
   assign o_reassign_lane  = role_r && copt_r[CO_LANE_BIT];

   always_comb begin
      join_pend_nxt = join_pend_r;
      retry_nxt     = 1'b0;
      poll_nxt      = i_pin_wake && !role_r && enopt_r[EN_POLL_BIT];
      if (i_joined || role_r) begin
         join_pend_nxt = 1'b0;
      end else if (join_pend_r && scan_bus.done &&
                   (enopt_r[EN_AUTO_BIT] || i_beacon_net)) begin
         retry_nxt = 1'b1;
      end
      // A new join request wins over a clear in the same cycle.
      if (i_join_start && !role_r) begin
         join_pend_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         join_pend_r <= 1'b0;
         retry_r     <= 1'b0;
         poll_r      <= 1'b0;
      end else begin
         join_pend_r <= join_pend_nxt;
         retry_r     <= retry_nxt;
         poll_r      <= poll_nxt;
      end
   end
   assign o_join_retry = retry_r;
   assign o_poll_req   = poll_r;

   // ***************************************************************
   // Checks.
   // ***************************************************************
   a_role_write: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_sel == 3'(JSC_SEL_ROLE)) |=> (role_r == $past(i_wdata[0])))
      else $error("Role flag write not visible.");
   a_enopt_resv: assert property (@(posedge i_mclk) disable iff (i_reset)
      (enopt_r & ~ENOPT_MASK) == 8'h00)
      else $error("Reserved end-node option bit set.");
   a_copt_resv: assert property (@(posedge i_mclk) disable iff (i_reset)
      (copt_r & ~COPT_MASK) == 8'h00)
      else $error("Reserved coordinator option bit set.");
   a_mask_hp: assert property (@(posedge i_mclk) disable iff (i_reset)
      !HIGH_POWER || (mask_r & MASK_HP_BAN) == 16'h0)
      else $error("Forbidden channel enabled on high-power variant.");
   a_poll_wake: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_pin_wake && !role_r && enopt_r[EN_POLL_BIT]) |=> o_poll_req)
      else $error("Pin wake did not poll.");
   a_scan_mask_use: assert property (@(posedge i_mclk) disable iff (i_reset)
      scan_bus.start |=> (o_active_mask == $past(mask_r) &&
      o_scan_busy == ($past(mask_r) != 16'h0)))
      else $error("Scan did not take the channel mask.");
   a_cand_pan: assert property (@(posedge i_mclk) disable iff (i_reset)
      (!enopt_r[EN_PAN_BIT] && i_cand_pan != i_pan_number) |-> !o_cand_ok)
      else $error("Joined a foreign network.");
   a_cand_lane: assert property (@(posedge i_mclk) disable iff (i_reset)
      (!enopt_r[EN_LANE_BIT] && i_cand_lane != i_radio_lane) |-> !o_cand_ok)
      else $error("Joined a foreign channel.");
   a_accept_gate: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_sel == 3'(JSC_SEL_COPT)) |=>
      (o_accept_joiners == (role_r && $past(i_wdata[CO_ACPT_BIT]))))
      else $error("Joiners accepted while disallowed.");
   c_scan_done: cover property (@(posedge i_mclk) disable iff (i_reset) o_scan_done);
   c_join_retry: cover property (@(posedge i_mclk) disable iff (i_reset) o_join_retry);
   c_poll: cover property (@(posedge i_mclk) disable iff (i_reset) o_poll_req);
endmodule : jsc_top

//--- verif/jsc_remote_node.sv
// Remote node model that answers a label lookup after a set delay.
`timescale 1ns/1ns
module jsc_remote_node (
   input  wire logic        i_mclk,  // System clock.
   input  wire logic        i_reset, // Asynchronous reset.
   input  wire logic        i_query, // Lookup broadcast pulse.
   input  wire logic [7:0]  i_delay, // Answer delay in cycles, zero for silence.
   input  wire logic [63:0] i_addr,  // Own address.
   output logic             o_match, // Answer pulse.
   output logic [63:0]      o_addr   // Address, valid only while answering.
);
   logic [7:0] cnt_r;
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) cnt_r <= 8'h00;
      else if (i_query) cnt_r <= i_delay;
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
   end
   assign o_match = (cnt_r == 8'h01);
   // Off the answer the lines carry the inverse so a stale capture shows up.
   assign o_addr  = o_match ? i_addr : ~i_addr;
endmodule : jsc_remote_node

//--- verif/tb_top.sv
// Self-checking testbench for the join and scan configuration block.
`timescale 1ns/1ns
module tb_top;
   import jsc_pkg::*;
   localparam int TMO = 50;
   localparam int UC  = 2;
   logic        clk, rst, wr, lk, lkp, scmd, jst, bcn, joined, wake, mt;
   logic        ok, er, ex, busy, done, cok, rty, poll, acc, rpan, rlane;
   logic [2:0]  sel;
   logic [15:0] wd, rd, amask, pan, cpan;
   logic [7:0]  lane, clane, dly;
   logic [3:0]  aexp;
   logic [31:0] alo, ahi;
   logic [63:0] maddr;
   logic [63:0] naddr = 64'h0123_4567_89ab_cdef;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   jsc_top #(.LOOKUP_TMO(TMO), .UNIT_CYC(UC)) jsc_top_i (
      .i_mclk(clk), .i_reset(rst), .i_wr(wr), .i_sel(sel), .i_wdata(wd), .o_rdata(rd),
      .i_lookup(lk), .i_lookup_param(lkp), .i_lookup_match(mt), .i_lookup_addr(maddr),
      .o_reply_ok(ok), .o_reply_err(er), .o_exit_cmd(ex), .o_target_addr_low(alo),
      .o_target_addr_high(ahi), .i_scan_cmd(scmd), .i_join_start(jst), .i_beacon_net(bcn),
      .o_scan_busy(busy), .o_scan_done(done), .o_active_mask(amask), .o_active_exp(aexp),
      .i_pan_number(pan), .i_radio_lane(lane), .i_cand_pan(cpan), .i_cand_lane(clane),
      .o_cand_ok(cok), .i_joined(joined), .o_join_retry(rty), .i_pin_wake(wake),
      .o_poll_req(poll), .o_accept_joiners(acc), .o_reassign_pan(rpan),
      .o_reassign_lane(rlane));
   jsc_remote_node jsc_remote_node_i (.i_mclk(clk), .i_reset(rst), .i_query(lk),
      .i_delay(dly), .i_addr(naddr), .o_match(mt), .o_addr(maddr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****************************************
   // Shared tasks.
   // ****************************************
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         tally_and_finish;
      end
   end
   task cyc;
      @(posedge clk);
      #1;
   endtask : cyc
   task chk(input bit c, input string m);
      cmp_count++;
      if (!c) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task rreg(input logic [2:0] s, input logic [15:0] e);
      sel = s;
      cyc;
      chk(rd === e, "register read");
   endtask : rreg
   // The strobe is dropped for one edge so two writes never meet in one time step.
   task wreg(input logic [2:0] s, input logic [15:0] d);
      sel = s;
      wd = d;
      wr = 1'b1;
      cyc;
      wr = 1'b0;
      cyc;
   endtask : wreg
   task wait_done(output int n);
      n = 1;
      cyc;
      while (done !== 1'b1 && n < 2000) begin
         cyc;
         n++;
      end
   endtask : wait_done
   // ****************************************
   // Scenarios.
   // ****************************************
   task t_regs;
      rreg(3'h0, 16'h0000);
      rreg(3'h1, 16'h1ffe);
      rreg(3'h2, 16'h0004);
      rreg(3'h3, 16'h0000);
      rreg(3'h4, 16'h0006);
      rreg(3'h5, 16'h0000);
      wreg(3'h0, 16'h0001);
      rreg(3'h0, 16'h0001);
      wreg(3'h2, 16'h000f);
      rreg(3'h2, 16'h000f);
      wreg(3'h3, 16'hffff);
      rreg(3'h3, 16'h000f);
      wreg(3'h4, 16'hffff);
      rreg(3'h4, 16'h0007);
      chk({acc, rpan, rlane} === 3'b111, "coordinator options on");
      wreg(3'h4, 16'h0000);
      chk({acc, rpan, rlane} === 3'b000, "coordinator options off");
      wreg(3'h5, 16'hffff);
      rreg(3'h5, 16'h0000);
   endtask : t_regs
   task t_lookup(input bit p, input logic [7:0] d, input int lo, input int hi, input bit g);
      int n;
      lk = 1'b1;
      lkp = p;
      dly = d;
      cyc;
      lk = 1'b0;
      lkp = 1'b0;
      n = 1;
      while (ok !== 1'b1 && er !== 1'b1 && n < 200) begin
         cyc;
         n++;
      end
      chk(n >= lo && n <= hi, "lookup reply time");
      chk(ok === g && ex === g && er === !g, "lookup reply kind");
      chk({ahi, alo} === naddr, "target address");
   endtask : t_lookup
   task t_scan(input logic [15:0] m, input logic [3:0] e);
      int n;
      wreg(3'h1, m);
      wreg(3'h2, {12'h000, e});
      scmd = 1'b1;
      cyc;
      scmd = 1'b0;
      chk(busy === 1'b1 && amask === m && aexp === e, "scan start");
      wait_done(n);
      chk(n == $countones(m) * (1 << e) * UC, "scan time");
      chk(busy === 1'b0, "scan idle after done");
   endtask : t_scan
   task t_join;
      int n;
      wreg(3'h0, 16'h0000);
      wreg(3'h2, 16'h0002);
      wreg(3'h3, 16'h0004);
      jst = 1'b1;
      cyc;
      jst = 1'b0;
      chk(busy === 1'b1, "end-node join scan");
      wait_done(n);
      cyc;
      chk(rty === 1'b1, "join retry");
      joined = 1'b1;
      wait_done(n);
      cyc;
      chk(rty === 1'b0, "no retry after join");
   endtask : t_join
   task t_policy;
      pan = 16'h1234;
      lane = 8'h0c;
      cpan = 16'h1235;
      clane = 8'h0c;
      wreg(3'h3, 16'h0000);
      chk(cok === 1'b0, "foreign network refused");
      wreg(3'h3, 16'h0001);
      chk(cok === 1'b1, "any network taken");
      cpan = pan;
      clane = 8'h0d;
      wreg(3'h3, 16'h0000);
      chk(cok === 1'b0, "foreign channel refused");
      wreg(3'h3, 16'h0002);
      chk(cok === 1'b1, "any channel taken");
      wreg(3'h3, 16'h0008);
      wake = 1'b1;
      cyc;
      wake = 1'b0;
      chk(poll === 1'b1, "poll on pin wake");
      wreg(3'h3, 16'h0000);
      wake = 1'b1;
      cyc;
      wake = 1'b0;
      chk(poll === 1'b0, "no poll with option clear");
   endtask : t_policy
   initial begin
      {rst, wr, lk, lkp, scmd, jst, bcn, joined, wake} = 9'h100;
      sel = 3'h0;
      wd = 16'h0000;
      pan = 16'h0000;
      cpan = 16'h0000;
      lane = 8'h00;
      clane = 8'h00;
      dly = 8'h00;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      t_regs;
      t_lookup(1'b1, 8'h03, 4, 4, 1'b1);
      t_lookup(1'b0, 8'h00, 1, 1, 1'b0);
      t_scan(16'h0003, 4'h1);
      t_scan(16'h8001, 4'h0);
      t_scan(16'h1ffe, 4'h2);
      t_join;
      t_policy;
      t_lookup(1'b1, 8'h3c, TMO, TMO + 2, 1'b0);
      tally_and_finish;
   end
endmodule : tb_top
